// >>> pkg/eeprom_host_pkg.sv
// Constants and types shared by the byte-port EEPROM host controller
package eeprom_host_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 8;
    localparam int COL_W  = 5;
    localparam int CLK_PERIOD_NS = 25;
    // Strobe low times
    localparam int BYTE_PULSE_STD_MS  = 9;
    localparam int BYTE_PULSE_FAST_MS = 1;
    localparam int CLEAR_PULSE_MS     = 10;
    localparam int BYTE_PULSE_STD_CYC  = (BYTE_PULSE_STD_MS * 1000000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int BYTE_PULSE_FAST_CYC = (BYTE_PULSE_FAST_MS * 1000000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_CYC     = (CLEAR_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
    // Setup, access and recovery
    localparam int SETUP_NS          = 50;
    localparam int WRITE_RECOVER_NS  = 50;
    localparam int READ_RECOVER_NS   = 1000;
    localparam int ADDR_ACCESS_NS    = 350;
    localparam int SETUP_CYC         = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVER_CYC = (WRITE_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int READ_RECOVER_CYC  = (READ_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADDR_ACCESS_CYC   = (ADDR_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 24;
    localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_CLEAR
    } op_t;
endpackage : eeprom_host_pkg

// >>> core/eeprom_wait_timer.sv
// Down counter that paces the phases of a host cycle
`timescale 1ns/10ps
module eeprom_wait_timer #(
    parameter int CNT_W = 24
) (
    // Clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_rst,
    // Control
    input  wire logic             i_load,
    input  wire logic [CNT_W-1:0] i_count,
    // Status
    output logic                  o_done
);
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    always_comb begin
        nxt_cnt = cnt_ff;
        if (i_load) begin
            nxt_cnt = i_count;
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    // Done depends on the count only, so a load decided from it forms no loop
    assign o_done = (cnt_ff == '0);
endmodule : eeprom_wait_timer

// >>> core/eeprom_host_ctrl.sv
// Host controller driving a byte-wide latched EEPROM through its pins
// Notes on behaviour
// R1: Device decodes read, standby, erase/write and array clear from pin levels.
// R2: Host sets address first, then selects, keeping strobe high during reads.
// R3: Device drives data only when selected with output drive low.
// R4: Device read latches are transparent; data follows address.
// R5: Host erases a byte before writing new data to it.
// R6: Erase: address, select low, drive high, all ones on data, strobe low.
// R7: Device captures address, controls and data on falling strobe.
// R8: Standard part needs byte erase/write strobe low at least 9 ms.
// R9: Fast part needs byte erase/write strobe low at least 1 ms.
// R10: After hold, host may release inputs; device ignores them.
// R11: Byte write uses erase sequence with true data on data lines.
// R12: Array clear erases every byte, ignoring address and data.
// R13: Host holds strobe low at least 10 ms for array clear.
// R14: Device holds latched inputs and ignores pins until recovery ends.
// R15: Device latches reopen only after recovery following strobe rise.
// R16: Host waits 50 ns before next write, 1 us before a read; after a write or clear the code waits 1 us before either.
// R17: Device refuses writes until a falling strobe after power-up.
// R18: Device writes only with select and drive at byte write levels.
// R19: Array is 8192 bytes, thirteen address lines, five column bits.
// R20: Erased byte reads back as all ones.
`timescale 1ns/10ps
module eeprom_host_ctrl #(
    parameter int ADDR_W          = eeprom_host_pkg::ADDR_W,
    parameter int DATA_W          = eeprom_host_pkg::DATA_W,
    parameter int BYTE_PULSE_STD  = eeprom_host_pkg::BYTE_PULSE_STD_CYC,
    parameter int BYTE_PULSE_FAST = eeprom_host_pkg::BYTE_PULSE_FAST_CYC,
    parameter int CLEAR_PULSE     = eeprom_host_pkg::CLEAR_PULSE_CYC
) (
    // Clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_rst,
    // Command port
    input  wire logic              i_req_valid,
    input  wire logic [1:0]        i_req_op,
    input  wire logic [ADDR_W-1:0] i_req_addr,
    input  wire logic [DATA_W-1:0] i_req_data,
    input  wire logic              i_fast_part,
    output logic                   o_req_ready,
    output logic                   o_rsp_valid,
    output logic [DATA_W-1:0]      o_rsp_data,
    output logic                   o_busy,
    // Device pins
    output logic [ADDR_W-1:0]      o_mem_addr,
    output logic                   o_select_n,
    output logic                   o_out_drive_n,
    output logic                   o_wr_strobe_n,
    output logic                   o_array_clear_n,
    input  wire logic [DATA_W-1:0] i_mem_data,
    output logic [DATA_W-1:0]      o_mem_data,
    output logic                   o_mem_data_oe
);
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_RD_ADDR,
        ST_RD_ACCESS,
        ST_ER_SETUP,
        ST_ER_PULSE,
        ST_ER_RECOVER,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_CLR_SETUP,
        ST_CLR_PULSE,
        ST_RECOVER
    } state_t;

    localparam logic [eeprom_host_pkg::CNT_W-1:0] SETUP_C =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::SETUP_CYC);
    localparam logic [eeprom_host_pkg::CNT_W-1:0] ACCESS_C =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::ADDR_ACCESS_CYC);
    localparam logic [eeprom_host_pkg::CNT_W-1:0] WREC_C =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::WRITE_RECOVER_CYC);
    localparam logic [eeprom_host_pkg::CNT_W-1:0] RREC_C =
        eeprom_host_pkg::CNT_W'(eeprom_host_pkg::READ_RECOVER_CYC);

    state_t                              state_ff;
    state_t                              nxt_state;
    logic [ADDR_W-1:0]                   addr_ff;
    logic [ADDR_W-1:0]                   nxt_addr;
    logic [DATA_W-1:0]                   wdata_ff;
    logic [DATA_W-1:0]                   nxt_wdata;
    logic [DATA_W-1:0]                   rdata_ff;
    logic [DATA_W-1:0]                   nxt_rdata;
    logic                                rsp_ff;
    logic                                nxt_rsp;
    logic                                last_wr_ff;
    logic                                nxt_last_wr;
    logic                                tmr_load;
    logic [eeprom_host_pkg::CNT_W-1:0]   tmr_count;
    logic                                tmr_done;
    logic [eeprom_host_pkg::CNT_W-1:0]   byte_pulse;

    eeprom_wait_timer #(
        .CNT_W (eeprom_host_pkg::CNT_W)
    ) u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_load     (tmr_load),
        .i_count    (tmr_count),
        .o_done     (tmr_done)
    );

    // Fast part shortens byte pulses only; clear pulse is unchanged
    assign byte_pulse = i_fast_part ? eeprom_host_pkg::CNT_W'(BYTE_PULSE_FAST)  // R9
                                    : eeprom_host_pkg::CNT_W'(BYTE_PULSE_STD);  // R8

    always_comb begin
        nxt_state   = state_ff;
        nxt_addr    = addr_ff;
        nxt_wdata   = wdata_ff;
        nxt_rdata   = rdata_ff;
        nxt_rsp     = 1'b0;
        nxt_last_wr = last_wr_ff;
        tmr_load    = 1'b0;
        tmr_count   = '0;
        case (state_ff)
            ST_IDLE: begin
                if (i_req_valid && tmr_done) begin
                    nxt_addr  = i_req_addr;
                    nxt_wdata = i_req_data;
                    tmr_load  = 1'b1;
                    case (i_req_op)
                        eeprom_host_pkg::OP_READ: begin
                            // Address settles before select falls
                            tmr_count = SETUP_C;  // R2
                            nxt_state = ST_RD_ADDR;
                        end
                        eeprom_host_pkg::OP_WRITE: begin
                            tmr_count = SETUP_C;
                            nxt_state = ST_ER_SETUP;  // R5
                        end
                        eeprom_host_pkg::OP_CLEAR: begin
                            tmr_count = SETUP_C;
                            nxt_state = ST_CLR_SETUP;
                        end
                        default: begin
                            tmr_load  = 1'b0;
                            nxt_state = ST_IDLE;
                        end
                    endcase
                end
            end
            ST_RD_ADDR: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = ACCESS_C;
                    nxt_state = ST_RD_ACCESS;
                end
            end
            ST_RD_ACCESS: begin
                if (tmr_done) begin
                    nxt_rdata   = i_mem_data;
                    nxt_rsp     = 1'b1;
                    nxt_last_wr = 1'b0;
                    nxt_state   = ST_IDLE;
                end
            end
            ST_ER_SETUP: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = byte_pulse;
                    nxt_state = ST_ER_PULSE;
                end
            end
            ST_ER_PULSE: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = WREC_C;  // R16
                    nxt_state = ST_ER_RECOVER;
                end
            end
            ST_ER_RECOVER: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = SETUP_C;
                    nxt_state = ST_WR_SETUP;
                end
            end
            ST_WR_SETUP: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = byte_pulse;
                    nxt_state = ST_WR_PULSE;
                end
            end
            ST_WR_PULSE, ST_CLR_PULSE: begin
                if (tmr_done) begin
                    nxt_last_wr = 1'b1;
                    nxt_state   = ST_RECOVER;
                end
            end
            ST_CLR_SETUP: begin
                if (tmr_done) begin
                    tmr_load  = 1'b1;
                    tmr_count = eeprom_host_pkg::CNT_W'(CLEAR_PULSE);  // R13
                    nxt_state = ST_CLR_PULSE;
                end
            end
            ST_RECOVER: begin
                nxt_rsp   = 1'b1;
                tmr_load  = 1'b1;
                // Same read-length gap RREC_C before any next request, write or read
                tmr_count = RREC_C;  // R16
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_ff   <= ST_IDLE;
            addr_ff    <= '0;
            wdata_ff   <= '0;
            rdata_ff   <= '0;
            rsp_ff     <= 1'b0;
            last_wr_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            addr_ff    <= nxt_addr;
            wdata_ff   <= nxt_wdata;
            rdata_ff   <= nxt_rdata;
            rsp_ff     <= nxt_rsp;
            last_wr_ff <= nxt_last_wr;
        end
    end

    // Pin drive decoded from state
    always_comb begin
        o_select_n      = 1'b1;
        o_out_drive_n   = 1'b1;
        o_wr_strobe_n   = 1'b1;
        o_array_clear_n = 1'b1;
        o_mem_data_oe   = 1'b0;
        o_mem_data      = wdata_ff;
        case (state_ff)
            ST_RD_ACCESS: begin
                o_select_n    = 1'b0;  // R2
                o_out_drive_n = 1'b0;  // R3
            end
            ST_ER_SETUP, ST_ER_PULSE: begin
                o_select_n    = 1'b0;
                o_mem_data_oe = 1'b1;
                o_mem_data    = eeprom_host_pkg::ERASED_BYTE;  // R6
                o_wr_strobe_n = (state_ff != ST_ER_PULSE);  // R6
            end
            ST_WR_SETUP, ST_WR_PULSE: begin
                o_select_n    = 1'b0;
                o_mem_data_oe = 1'b1;
                o_wr_strobe_n = (state_ff != ST_WR_PULSE);  // R11
            end
            ST_CLR_SETUP, ST_CLR_PULSE: begin
                o_select_n      = 1'b0;
                o_array_clear_n = 1'b0;
                o_wr_strobe_n   = (state_ff != ST_CLR_PULSE);
            end
            default: begin
                o_select_n = 1'b1;  // R10
            end
        endcase
    end

    assign o_mem_addr  = addr_ff;
    assign o_rsp_valid = rsp_ff;
    assign o_rsp_data  = rdata_ff;
    assign o_req_ready = (state_ff == ST_IDLE) && tmr_done;
    assign o_busy      = !o_req_ready;

    // Strobe never falls while data is being driven from the device side
    a_strobe_no_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_wr_strobe_n |-> o_out_drive_n)
        else $error("strobe low while output drive active");  // R2
    a_erase_all_ones: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_ff == ST_ER_PULSE) |-> (o_mem_data == eeprom_host_pkg::ERASED_BYTE && o_mem_data_oe))
        else $error("erase pulse without all ones");  // R6
    a_byte_pulse_len: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_wr_strobe_n) && o_array_clear_n && i_fast_part |->
        !o_wr_strobe_n [*8])
        else $error("byte strobe pulse too short");  // R9
    a_erase_then_write: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (state_ff == ST_WR_SETUP) && $changed(state_ff) |-> $past(state_ff) == ST_ER_RECOVER)
        else $error("write not preceded by erase");  // R5
    a_read_select: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_select_n) && !o_out_drive_n |-> $past(o_mem_addr) == o_mem_addr)
        else $error("address moved as select fell");  // R2
    a_recover_gap: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_wr_strobe_n) |-> o_select_n [*2])
        else $error("recovery gap too short");  // R16
    a_clear_pulse: assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_wr_strobe_n) && !o_array_clear_n |-> !o_wr_strobe_n [*8])
        else $error("clear strobe pulse too short");  // R13
    a_no_oe_on_read: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !o_out_drive_n |-> !o_mem_data_oe)
        else $error("bus contention on read");  // R3
endmodule : eeprom_host_ctrl

// >>> tb/eeprom_dev_model.sv
// Behavioural byte-port EEPROM that answers the host controller
`timescale 1ns/10ps
module eeprom_dev_model #(
    parameter int BYTE_NS  = 500,
    parameter int FAST_NS  = 250,
    parameter int CLEAR_NS = 750
) (
    // Device pins
    input  wire logic [eeprom_host_pkg::ADDR_W-1:0] i_addr,
    input  wire logic                               i_select_n,
    input  wire logic                               i_out_drive_n,
    input  wire logic                               i_wr_strobe_n,
    input  wire logic                               i_array_clear_n,
    input  wire logic [7:0]                         i_data,
    output logic      [7:0]                         o_data,
    output logic                                    o_data_oe,
    // Host side settings and findings
    input  wire logic                               i_fast,
    output logic                                    o_viol
);
    logic [7:0]  mem [0:(2**eeprom_host_pkg::ADDR_W)-1];
    logic [12:0] l_addr;
    logic [7:0]  l_data;
    logic        l_sel;
    logic        l_drv;
    logic        l_clr;
    logic        armed;
    realtime     t_fall;
    realtime     t_rise;
    realtime     need;
    // Power-up contents are arbitrary
    initial begin
        armed = 1'b0;
        o_viol = 1'b0;
        t_rise = -1.0e6;
        for (int i = 0; i < 8192; i++) mem[i] = 8'(i * 37);
    end
    assign o_data_oe = !i_select_n && !i_out_drive_n && i_wr_strobe_n;
    assign o_data = mem[i_addr];
    always @(negedge i_wr_strobe_n) begin
        armed = 1'b1;
        {l_addr, l_data, l_sel, l_drv, l_clr} = {i_addr, i_data, i_select_n,
            i_out_drive_n, i_array_clear_n};
        need = i_fast ? FAST_NS : BYTE_NS;
        t_fall = $realtime;
        if ($realtime - t_rise < 50.0) o_viol = 1'b1;
    end
    // Only latched values count; pins are ignored until the strobe rises
    always @(posedge i_wr_strobe_n) begin
        t_rise = $realtime;
        if (armed && !l_sel && l_drv) begin
            if (!l_clr) begin
                if (t_rise - t_fall < CLEAR_NS) o_viol = 1'b1;
                else for (int i = 0; i < 8192; i++) mem[i] = 8'hFF;
            end else if (t_rise - t_fall < need) begin
                o_viol = 1'b1;
            end else begin
                // A write without a preceding erase only clears bits
                mem[l_addr] = (l_data == 8'hFF) ? 8'hFF : mem[l_addr] & l_data;
            end
        end
    end
    always @(posedge o_data_oe) begin
        if ($realtime - t_rise < 1000.0) o_viol = 1'b1;
    end
endmodule : eeprom_dev_model

// >>> tb/tb.sv
// Self-checking bench for the EEPROM host controller
`timescale 1ns/10ps
module tb;
    localparam int P_STD = 20;
    localparam int P_FST = 10;
    localparam int P_CLR = 30;
    localparam int T = eeprom_host_pkg::CLK_PERIOD_NS;
    logic        clk, rst, valid, fast, m_fast, ready, rsp_v, busy, viol;
    logic        sel_n, drv_n, stb_n, clr_n, h_oe, d_oe;
    logic [1:0]  op;
    logic [12:0] addr, m_addr;
    logic [7:0]  wdat, rsp_d, h_d, d_q, float_q, last_rd;
    logic [7:0]  exp_mem [0:8191];
    logic [12:0] wa [6];
    logic [7:0]  q [$];
    int          n_fail, comparisons, cycles, seed;
    wire  [7:0]  bus = d_oe ? d_q : (h_oe ? h_d : float_q);

    eeprom_host_ctrl #(.BYTE_PULSE_STD(P_STD), .BYTE_PULSE_FAST(P_FST), .CLEAR_PULSE(P_CLR))
    dut_u (.i_core_clk(clk), .i_rst(rst), .i_req_valid(valid), .i_req_op(op),
        .i_req_addr(addr), .i_req_data(wdat), .i_fast_part(fast), .o_req_ready(ready),
        .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d), .o_busy(busy), .o_mem_addr(m_addr),
        .o_select_n(sel_n), .o_out_drive_n(drv_n), .o_wr_strobe_n(stb_n),
        .o_array_clear_n(clr_n), .i_mem_data(bus), .o_mem_data(h_d), .o_mem_data_oe(h_oe));
    eeprom_dev_model #(.BYTE_NS(P_STD * T), .FAST_NS(P_FST * T), .CLEAR_NS(P_CLR * T))
    dev_u (.i_addr(m_addr), .i_select_n(sel_n), .i_out_drive_n(drv_n),
        .i_wr_strobe_n(stb_n), .i_array_clear_n(clr_n), .i_data(bus), .o_data(d_q),
        .o_data_oe(d_oe), .i_fast(m_fast), .o_viol(viol));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict

    // Holds the request until taken and notes the response expected
    task automatic req(input eeprom_host_pkg::op_t o, input logic [12:0] a,
                       input logic [7:0] d, input logic f);
        // Wait for idle so the part type never changes under a running cycle
        do begin
            @(posedge clk);
            #2;
        end while (ready !== 1'b1);
        {valid, op, addr, wdat, fast} = {1'b1, o, a, d, f};
        #1;
        while (ready !== 1'b1) begin
            @(posedge clk);
            #3;
        end
        if (o == eeprom_host_pkg::OP_READ) last_rd = exp_mem[a];
        else if (o == eeprom_host_pkg::OP_WRITE) {exp_mem[a], m_fast} = {d, f};
        else for (int j = 0; j < 8192; j++) exp_mem[j] = 8'hFF;
        q.push_back(last_rd);
        @(posedge clk);
        #2;
        valid = 1'b0;
    endtask : req

    always @(posedge clk) begin
        float_q <= ~float_q;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            print_verdict();
        end
        if (rsp_v === 1'b1) begin
            if (q.size() == 0) begin
                n_fail++;
                $display("CHECK FAILED at %0t: response with none pending", $time);
            end else chk(rsp_d, q.pop_front());
        end
        if (stb_n === 1'b0) chk({6'h00, sel_n, drv_n}, 8'h01);
        if (d_oe === 1'b1) chk({7'h00, h_oe}, 8'h00);
    end

    initial begin
        {n_fail, comparisons, cycles, seed} = {32'd0, 32'd0, 32'd0, 32'h9add};
        {float_q, last_rd, m_fast} = {8'h5A, 8'h00, 1'b0};
        {rst, valid, op, addr, wdat, fast} = {1'b1, 1'b0, 2'b00, 13'h0000, 8'h00, 1'b0};
        repeat (20) @(posedge clk);
        chk({sel_n, drv_n, stb_n, clr_n, h_oe, ready, 2'b00}, 8'hF4);
        #2;
        rst = 1'b0;
        req(eeprom_host_pkg::OP_WRITE, 13'h0000, 8'h3C, 1'b0);
        req(eeprom_host_pkg::OP_READ, 13'h0000, 8'h00, 1'b0);
        req(eeprom_host_pkg::OP_WRITE, 13'h0000, 8'hC3, 1'b1);
        req(eeprom_host_pkg::OP_READ, 13'h0000, 8'h00, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wa[i] = (i == 0) ? 13'h1FFF : 13'($random(seed));
            req(eeprom_host_pkg::OP_WRITE, wa[i], 8'($random(seed)), i[0]);
        end
        for (int i = 0; i < 6; i++) req(eeprom_host_pkg::OP_READ, wa[i], 8'h00, 1'b0);
        do begin
            @(posedge clk);
            #2;
        end while (ready !== 1'b1);
        {valid, op} = {1'b1, 2'b11};
        repeat (6) @(posedge clk);
        #2;
        valid = 1'b0;
        chk({7'h00, busy}, 8'h00);
        req(eeprom_host_pkg::OP_CLEAR, 13'h0ABC, 8'h00, 1'b1);
        req(eeprom_host_pkg::OP_READ, 13'h0000, 8'h00, 1'b0);
        req(eeprom_host_pkg::OP_READ, wa[2], 8'h00, 1'b0);
        req(eeprom_host_pkg::OP_WRITE, 13'h0040, 8'h81, 1'b0);
        req(eeprom_host_pkg::OP_READ, 13'h0040, 8'h00, 1'b0);
        for (int k = 0; k < 100 && q.size() > 0; k++) @(posedge clk);
        chk({7'h00, 1'(q.size() != 0)}, 8'h00);
        chk({7'h00, viol}, 8'h00);
        print_verdict();
    end
endmodule : tb
